// file: src/adcwt_pkg.sv
// package: register map, field layout, reset values and carriers for the window/peak block
`default_nettype none
package adcwt_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 12;

  localparam logic [7:0] ADDR_CH6_LOW_BYTE   = 8'h3b;
  localparam logic [7:0] ADDR_CH7_MARGIN     = 8'h3c;
  localparam logic [7:0] ADDR_CH7_HIGH_BYTE  = 8'h3d;
  localparam logic [7:0] ADDR_CH7_FILTER     = 8'h3e;
  localparam logic [7:0] ADDR_CH7_LOW_BYTE   = 8'h3f;
  localparam logic [7:0] ADDR_CH0_PEAK_LOW   = 8'h60;
  localparam logic [7:0] ADDR_CH0_PEAK_HIGH  = 8'h61;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h70;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h71;

  localparam logic [7:0] RST_CH7_MARGIN    = 8'hf0;
  localparam logic [7:0] RST_CH7_HIGH_BYTE = 8'hff;
  localparam logic [7:0] RST_CH7_FILTER    = 8'h00;
  localparam logic [7:0] RST_CH7_LOW_BYTE  = 8'h00;
  localparam logic [7:0] RST_CH6_LOW_BYTE  = 8'h00;
  localparam logic [7:0] RST_PEAK          = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK      = 8'h00;

  localparam int unsigned NIB_HI_MSB = 7;
  localparam int unsigned NIB_HI_LSB = 4;
  localparam int unsigned NIB_LO_MSB = 3;
  localparam int unsigned NIB_LO_LSB = 0;
  localparam int unsigned MARGIN_SHIFT = 3;
  localparam int unsigned MARGIN_W = 7;

  localparam int unsigned IRQ_HIGH_BIT = 0;
  localparam int unsigned IRQ_LOW_BIT  = 1;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } adcwt_bus_s;

  typedef struct packed {
    logic              valid;
    logic [2:0]        chan;
    logic [CODE_W-1:0] code;
  } adcwt_sample_s;
endpackage
`default_nettype wire

// file: src/adcwt_filter.sv
// consecutive-sample event filter for one watchdog direction
`timescale 1ns/1ns
`default_nettype none
module adcwt_filter #(
  parameter int unsigned CNT_W = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_sample,
  input  wire logic             i_beyond,
  input  wire logic [CNT_W-1:0] i_limit,
  output logic                  o_fire
);
  // one wider than the limit so that n+1 can be counted at n = all ones
  logic [CNT_W:0] run;
  wire  [CNT_W:0] limit_ext = {1'b0, i_limit};
  wire  [CNT_W:0] run_inc   = run + {{CNT_W{1'b0}}, 1'b1};

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run <= '0;
    end else if (i_sample) begin
      run <= i_beyond ? ((run > limit_ext) ? run : run_inc) : '0;
    end
  end

  // fires on the sample that completes n+1 in a row, once per excursion
  assign o_fire = i_sample && i_beyond && (run == limit_ext);
endmodule
`default_nettype wire

// file: src/adcwt_top.sv
// window comparator settings, ch7 watchdog and ch0 peak recorder with register port
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module adcwt_top
  import adcwt_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire adcwt_pkg::adcwt_bus_s   i_bus,
  output logic [adcwt_pkg::DATA_W-1:0] o_rdata,
  input  wire adcwt_pkg::adcwt_sample_s i_sample,
  output logic                         o_ch7_high_event,
  output logic                         o_ch7_low_event,
  output logic                         o_irq
);
  import adcwt_pkg::*;

  // ==========================================================
  // register storage
  logic [7:0] ch7_window_margin;
  logic [7:0] ch7_upper_limit_byte;
  logic [7:0] ch7_sample_filter_count;
  logic [7:0] ch7_lower_limit_byte;
  logic [7:0] ch6_lower_limit_byte;
  logic [CODE_W-1:0] ch0_peak;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  // the high byte is latched when the low byte is read so a pair reads coherently
  logic [7:0] peak_high_hold;
  logic       hold_valid;

  // ==========================================================
  // address decode
  wire hit_margin  = (i_bus.addr == ADDR_CH7_MARGIN);
  wire hit_high    = (i_bus.addr == ADDR_CH7_HIGH_BYTE);
  wire hit_filter  = (i_bus.addr == ADDR_CH7_FILTER);
  wire hit_low     = (i_bus.addr == ADDR_CH7_LOW_BYTE);
  wire hit_ch6_low = (i_bus.addr == ADDR_CH6_LOW_BYTE);
  wire hit_pk_lo   = (i_bus.addr == ADDR_CH0_PEAK_LOW);
  wire hit_pk_hi   = (i_bus.addr == ADDR_CH0_PEAK_HIGH);
  wire hit_status  = (i_bus.addr == ADDR_IRQ_STATUS);
  wire hit_mask    = (i_bus.addr == ADDR_IRQ_MASK);

  wire rd_pk_lo = i_bus.rd && hit_pk_lo;
  wire rd_pk_hi = i_bus.rd && hit_pk_hi;
  wire peak_read = rd_pk_lo || rd_pk_hi;

  // ==========================================================
  // threshold assembly
  wire [3:0] ch7_upper_limit_low_nibble = ch7_window_margin[NIB_HI_MSB:NIB_HI_LSB];
  wire [3:0] ch7_lower_limit_low_nibble = ch7_sample_filter_count[NIB_HI_MSB:NIB_HI_LSB];
  wire [3:0] margin_nib  = ch7_window_margin[NIB_LO_MSB:NIB_LO_LSB];
  wire [3:0] filter_n    = ch7_sample_filter_count[NIB_LO_MSB:NIB_LO_LSB];
  // byte meets result[11:4], nibble meets result[3:0]
  wire [CODE_W-1:0] upper_th = {ch7_upper_limit_byte, ch7_upper_limit_low_nibble};
  wire [CODE_W-1:0] lower_th = {ch7_lower_limit_byte, ch7_lower_limit_low_nibble};
  wire [MARGIN_W-1:0] hyst = {margin_nib, 3'h0};

  // ==========================================================
  // window comparison with hysteresis
  // once beyond a limit, the code must return past limit -/+ hyst to rearm
  logic above_state;
  logic below_state;
  wire ch7_sample = i_sample.valid && (i_sample.chan == 3'h7);
  wire ch0_sample = i_sample.valid && (i_sample.chan == 3'h0);
  wire [CODE_W:0] code_x    = {1'b0, i_sample.code};
  wire [CODE_W:0] upper_x   = {1'b0, upper_th};
  wire [CODE_W:0] lower_x   = {1'b0, lower_th};
  wire [CODE_W:0] hyst_x    = {{(CODE_W+1-MARGIN_W){1'b0}}, hyst};
  // 13-bit sums avoid wraparound near full scale and zero
  wire above_hi  = code_x > upper_x;
  wire below_lo  = code_x < lower_x;
  wire rearm_hi  = (code_x + hyst_x) <= upper_x;
  wire rearm_lo  = code_x >= (lower_x + hyst_x);
  wire beyond_hi = above_hi || (above_state && !rearm_hi);
  wire beyond_lo = below_lo || (below_state && !rearm_lo);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      above_state <= 1'b0;
      below_state <= 1'b0;
    end else if (ch7_sample) begin
      above_state <= beyond_hi;
      below_state <= beyond_lo;
    end
  end

  logic fire_hi;
  logic fire_lo;
  adcwt_filter #(.CNT_W(4)) u_filt_hi (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_sample (ch7_sample),
    .i_beyond (beyond_hi),
    .i_limit  (filter_n),
    .o_fire   (fire_hi)
  );
  adcwt_filter #(.CNT_W(4)) u_filt_lo (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_sample (ch7_sample),
    .i_beyond (beyond_lo),
    .i_limit  (filter_n),
    .o_fire   (fire_lo)
  );

  // ==========================================================
  // configuration writes
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ch7_window_margin       <= RST_CH7_MARGIN;
      ch7_upper_limit_byte    <= RST_CH7_HIGH_BYTE;
      ch7_sample_filter_count <= RST_CH7_FILTER;
      ch7_lower_limit_byte    <= RST_CH7_LOW_BYTE;
      ch6_lower_limit_byte    <= RST_CH6_LOW_BYTE;
      irq_mask                <= RST_IRQ_MASK[1:0];
    end else if (i_bus.wr) begin
      if (hit_margin) begin
        ch7_window_margin <= i_bus.wdata;
      end else if (hit_high) begin
        ch7_upper_limit_byte <= i_bus.wdata;
      end else if (hit_filter) begin
        ch7_sample_filter_count <= i_bus.wdata;
      end else if (hit_low) begin
        ch7_lower_limit_byte <= i_bus.wdata;
      end else if (hit_ch6_low) begin
        ch6_lower_limit_byte <= i_bus.wdata;
      end else if (hit_mask) begin
        irq_mask <= i_bus.wdata[1:0];
      end
    end
  end

  // ==========================================================
  // peak recorder: a sample in the read cycle survives the clear
  wire [CODE_W-1:0] peak_base = peak_read ? '0 : ch0_peak;
  wire [CODE_W-1:0] next_peak =
    (ch0_sample && (i_sample.code > peak_base)) ? i_sample.code : peak_base;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ch0_peak       <= {RST_PEAK[3:0], RST_PEAK};
      peak_high_hold <= RST_PEAK;
      hold_valid     <= 1'b0;
    end else begin
      ch0_peak <= next_peak;
      if (rd_pk_lo) begin
        peak_high_hold <= {4'h0, ch0_peak[CODE_W-1:8]};
        hold_valid     <= 1'b1;
      end else if (rd_pk_hi) begin
        hold_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt status: set wins over write-one-to-clear
  wire [1:0] ev_set = {fire_lo, fire_hi};
  wire [1:0] w1c    = (i_bus.wr && hit_status) ? i_bus.wdata[1:0] : 2'h0;
  wire [1:0] next_status = (irq_status & ~w1c) | ev_set;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= next_status;
    end
  end

  assign o_irq            = |(irq_status & irq_mask);
  assign o_ch7_high_event = irq_status[IRQ_HIGH_BIT];
  assign o_ch7_low_event  = irq_status[IRQ_LOW_BIT];

  // ==========================================================
  // read data, one cycle after the strobe; unmapped reads return zero
  wire [7:0] peak_hi_view = hold_valid ? peak_high_hold : {4'h0, ch0_peak[CODE_W-1:8]};
  wire [7:0] rd_mux =
    hit_margin  ? ch7_window_margin :
    hit_high    ? ch7_upper_limit_byte :
    hit_filter  ? ch7_sample_filter_count :
    hit_low     ? ch7_lower_limit_byte :
    hit_ch6_low ? ch6_lower_limit_byte :
    hit_pk_lo   ? ch0_peak[7:0] :
    hit_pk_hi   ? peak_hi_view :
    hit_status  ? {6'h00, irq_status} :
    hit_mask    ? {6'h00, irq_mask} : 8'h00;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_bus.rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // checks
  sequence peak_rd_s;
    rd_pk_lo && !ch0_sample;
  endsequence

  sequence peak_hi_rd_s;
    rd_pk_hi && !ch0_sample;
  endsequence

  sequence pair_rd_s;
    rd_pk_lo ##1 !i_bus.rd ##1 rd_pk_hi;
  endsequence

  sequence calm_hi_s;
    ch7_sample && !beyond_hi;
  endsequence

  sequence calm_lo_s;
    ch7_sample && !beyond_lo;
  endsequence

  // one idle cycle, then a sample that needs more than one in a row
  sequence next_sample_s;
    (!ch7_sample)[*1] ##1 (ch7_sample && filter_n != 4'h0);
  endsequence

  peak_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
    peak_rd_s |=> ch0_peak == '0)
    else $error("peak not cleared by read");

  peak_track_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (ch0_sample && !peak_read && i_sample.code > ch0_peak) |=> ch0_peak == $past(i_sample.code))
    else $error("peak did not follow larger code");

  peak_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (!ch0_sample && !peak_read) |=> $stable(ch0_peak))
    else $error("peak moved without sample");

  reset_vals_a: assert property (@(posedge i_clk)
    ($past(i_srst) && !i_srst) |-> ch7_window_margin == 8'hf0 && ch7_upper_limit_byte == 8'hff)
    else $error("bad reset of margin or high byte");

  reset_zero_a: assert property (@(posedge i_clk)
    ($past(i_srst) && !i_srst) |-> ch7_sample_filter_count == 8'h00 &&
      ch7_lower_limit_byte == 8'h00)
    else $error("bad reset of filter or low byte");

  high_thresh_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_sample.code[11:4] > ch7_upper_limit_byte ||
     (i_sample.code[11:4] == ch7_upper_limit_byte &&
      i_sample.code[3:0] > ch7_window_margin[7:4])) |-> beyond_hi)
    else $error("high threshold assembly wrong");

  low_thresh_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_sample.code[11:4] < ch7_lower_limit_byte ||
     (i_sample.code[11:4] == ch7_lower_limit_byte &&
      i_sample.code[3:0] < ch7_sample_filter_count[7:4])) |-> beyond_lo)
    else $error("low threshold assembly wrong");

  no_early_event_a: assert property (@(posedge i_clk) disable iff (i_srst)
    calm_hi_s ##1 next_sample_s
      |-> !fire_hi)
    else $error("event without enough samples");

  irq_level_a: assert property (@(posedge i_clk) disable iff (i_srst)
    fire_hi |=> irq_status[IRQ_HIGH_BIT])
    else $error("high event lost");

  read_data_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bus.rd && hit_high) |=> o_rdata == $past(ch7_upper_limit_byte))
    else $error("high byte read wrong");

  no_low_early_a: assert property (@(posedge i_clk) disable iff (i_srst)
    calm_lo_s ##1 next_sample_s
      |-> !fire_lo)
    else $error("low event without enough samples");

  irq_low_a: assert property (@(posedge i_clk) disable iff (i_srst)
    fire_lo |=> irq_status[IRQ_LOW_BIT])
    else $error("low event lost");

  // ==========================================================
  // status, register write-through, peak clear and reads, read idle, resets, low hysteresis
  status_sticky_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_status[IRQ_HIGH_BIT] && !(i_bus.wr && hit_status && i_bus.wdata[IRQ_HIGH_BIT]))
      |=> irq_status[IRQ_HIGH_BIT])
    else $error("high event not sticky");

  status_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bus.wr && hit_status && i_bus.wdata[IRQ_HIGH_BIT] && !fire_hi)
      |=> !irq_status[IRQ_HIGH_BIT])
    else $error("high event not cleared");

  status_quiet_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (!ch7_sample && !(i_bus.wr && hit_status)) |=> $stable(irq_status))
    else $error("status moved without sample");

  margin_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bus.wr && hit_margin) |=> ch7_window_margin == $past(i_bus.wdata))
    else $error("margin write lost");

  high_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bus.wr && hit_high) |=> ch7_upper_limit_byte == $past(i_bus.wdata))
    else $error("high byte write lost");

  filter_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bus.wr && hit_filter) |=> ch7_sample_filter_count == $past(i_bus.wdata))
    else $error("filter write lost");

  low_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bus.wr && hit_low) |=> ch7_lower_limit_byte == $past(i_bus.wdata))
    else $error("low byte write lost");

  ch6_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_bus.wr && hit_ch6_low) |=> ch6_lower_limit_byte == $past(i_bus.wdata))
    else $error("ch6 low byte write lost");

  peak_hi_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
    peak_hi_rd_s |=> ch0_peak == '0)
    else $error("peak not cleared by high read");

  peak_low_read_a: assert property (@(posedge i_clk) disable iff (i_srst)
    rd_pk_lo |=> o_rdata == $past(ch0_peak[7:0]))
    else $error("peak low byte read wrong");

  peak_pair_a: assert property (@(posedge i_clk) disable iff (i_srst)
    pair_rd_s |=> o_rdata == {4'h0, $past(ch0_peak[CODE_W-1:8], 3)})
    else $error("peak high byte not coherent");

  rdata_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data not idle");

  reset_other_a: assert property (@(posedge i_clk)
    ($past(i_srst) && !i_srst) |-> irq_status == 2'h0 && ch0_peak == '0 &&
      o_rdata == 8'h00 && ch6_lower_limit_byte == 8'h00)
    else $error("bad reset of status, peak or read data");

  margin_low_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (below_state && !below_lo && code_x < lower_x + {6'h00, margin_nib, 3'h0})
      |-> beyond_lo)
    else $error("low limit rearmed inside hysteresis");
endmodule
`default_nettype wire

// file: tb/adcwt_host.sv
// host-side register master model for the window/peak block
`timescale 1ns/1ns
`default_nettype none
module adcwt_host (
  input  wire logic [adcwt_pkg::DATA_W-1:0] i_rdata,
  input  wire logic                         i_clk,
  output var  adcwt_pkg::adcwt_bus_s        o_bus
);
  import adcwt_pkg::*;
  initial o_bus = '0;
  // ===
  // bus cycles
  // released lines show the inverse so stale values never pass
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    @(negedge i_clk);
    d = i_rdata; // one read of a peak register is all it takes to clear it
  endtask
endmodule
`default_nettype wire

// file: tb/tb_adcwt_top.sv
// self-checking bench: register map, ch7 watchdog, ch0 peak recorder
`timescale 1ns/1ns
`default_nettype none
module tb_adcwt_top;
  import adcwt_pkg::*;
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  adcwt_bus_s    bus;
  adcwt_sample_s smp = '0;
  logic [7:0]    rdata;
  logic          hi_ev;
  logic          lo_ev;
  logic          irq;
  int            fails = 0;
  int            check_count = 0;
  logic [11:0]   hseq [5] = '{12'h109, 12'h109, 12'h108, 12'h109, 12'h109};
  initial begin
    forever #25 clk = ~clk;
  end
  adcwt_top adcwt_top_i (.i_clk(clk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata),
    .i_sample(smp), .o_ch7_high_event(hi_ev), .o_ch7_low_event(lo_ev), .o_irq(irq));
  adcwt_host adcwt_host_i (.i_rdata(rdata), .i_clk(clk), .o_bus(bus));
  // ===
  // compare and access tasks
  task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk1(input string w, input logic e, input logic g);
    chk8(w, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rd_chk(input string w, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    adcwt_host_i.rd_reg(a, d);
    chk8(w, e, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    adcwt_host_i.wr_reg(a, d);
  endtask
  // code is inverted on release, the converter no longer holds it
  task automatic send(input logic [2:0] ch, input logic [11:0] code);
    @(posedge clk);
    smp <= '{valid: 1'b1, chan: ch, code: code};
    @(posedge clk);
    smp <= '{valid: 1'b0, chan: ~ch, code: ~code};
    @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ===
  // watchdog: the run needs about 115 cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  // ===
  // tests
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd_chk("margin", ADDR_CH7_MARGIN, 8'hf0);
    rd_chk("high byte", ADDR_CH7_HIGH_BYTE, 8'hff);
    rd_chk("filter", ADDR_CH7_FILTER, 8'h00);
    rd_chk("low byte", ADDR_CH7_LOW_BYTE, 8'h00);
    rd_chk("ch6 low", ADDR_CH6_LOW_BYTE, 8'h00);
    rd_chk("mask", ADDR_IRQ_MASK, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CH6_LOW_BYTE + 8'(i), 8'h5a + 8'(i));
      rd_chk("rw", ADDR_CH6_LOW_BYTE + 8'(i), 8'h5a + 8'(i));
    end
    // peak recorder: read-only, other channels ignored, cleared by a read
    wr(ADDR_CH0_PEAK_LOW, 8'hff);
    send(3'd0, 12'h5a3);
    send(3'd0, 12'h1ff);
    send(3'd3, 12'hfff);
    rd_chk("peak lo", ADDR_CH0_PEAK_LOW, 8'ha3);
    rd_chk("peak hi", ADDR_CH0_PEAK_HIGH, 8'h05);
    send(3'd0, 12'h012);
    rd_chk("peak lo", ADDR_CH0_PEAK_LOW, 8'h12);
    rd_chk("peak hi", ADDR_CH0_PEAK_HIGH, 8'h00);
    // high limit 0x108, n = 2: equal is not beyond, a gap restarts the run
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_CH7_HIGH_BYTE, 8'h10);
    wr(ADDR_CH7_MARGIN, 8'h80);
    wr(ADDR_CH7_FILTER, 8'h02);
    wr(ADDR_CH7_LOW_BYTE, 8'h00);
    foreach (hseq[i]) begin
      send(3'd7, hseq[i]);
      chk1("high ev", 1'b0, hi_ev);
    end
    send(3'd7, 12'h109);
    chk1("high ev", 1'b1, hi_ev);
    chk1("irq", 1'b1, irq);
    rd_chk("status", ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    rd_chk("status", ADDR_IRQ_STATUS, 8'h00);
    chk1("irq", 1'b0, irq);
    // low limit 0x204 with 8 codes of hysteresis, n = 0, masked first
    wr(ADDR_CH7_HIGH_BYTE, 8'hf0);
    wr(ADDR_CH7_MARGIN, 8'h81);
    wr(ADDR_CH7_LOW_BYTE, 8'h20);
    wr(ADDR_CH7_FILTER, 8'h40);
    wr(ADDR_IRQ_MASK, 8'h01);
    send(3'd7, 12'h204);
    chk1("low ev", 1'b0, lo_ev);
    send(3'd7, 12'h203);
    chk1("low ev", 1'b1, lo_ev);
    chk1("irq", 1'b0, irq);
    wr(ADDR_IRQ_STATUS, 8'h02);
    send(3'd7, 12'h20b);
    send(3'd7, 12'h203);
    chk1("low ev", 1'b0, lo_ev);
    send(3'd7, 12'h20c);
    send(3'd7, 12'h203);
    chk1("low ev", 1'b1, lo_ev);
    chk1("high ev", 1'b0, hi_ev);
    wr(ADDR_IRQ_MASK, 8'h02);
    @(negedge clk);
    chk1("irq", 1'b1, irq);
    report_and_stop();
  end
endmodule
`default_nettype wire
